/* File: design/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_BASIC_EN   = 8'h00;
	localparam logic [7:0] OFS_BASIC_PRIO = 8'h04;
	localparam logic [7:0] OFS_EXT_EN     = 8'h08;
	localparam logic [7:0] OFS_EXT_PRIO   = 8'h0c;
	localparam logic [7:0] OFS_EXT_FLAG   = 8'h10;
	localparam logic [7:0] OFS_EXT_CTRL   = 8'h14;
	localparam logic [7:0] OFS_TIMER_CTRL = 8'h18;
	localparam logic [7:0] OFS_SERIAL     = 8'h1c;
	localparam logic [7:0] OFS_T2_CTRL    = 8'h20;
	localparam logic [7:0] OFS_STATUS     = 8'h24;

	// Field positions
	localparam int GLOBAL_EN_BIT = 7;
	localparam int IT0_BIT       = 0;
	localparam int IE0_BIT       = 1;
	localparam int IT1_BIT       = 2;
	localparam int IE1_BIT       = 3;
	localparam int TF0_BIT       = 5;
	localparam int TF1_BIT       = 7;
	localparam int RX_BIT        = 0;
	localparam int TX_BIT        = 1;
	localparam int TIMER2_EXTERNAL_FLAG_BIT      = 6;
	localparam int TF2_BIT       = 7;
	localparam int EXT_FLAG_LSB  = 4;
	localparam int WAKE_BIT      = 3;

	// Reset values and reserved fill
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [2:0] RSVD_ONES = 3'h7;

	// AHB encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// Sources in natural order, lowest index wins a tie
	localparam int          NUM_SRC  = 11;
	localparam logic [3:0]  SRC_EXT0 = 4'h0;
	localparam logic [3:0]  SRC_EXT1 = 4'h2;
	localparam logic [3:0]  SRC_T1   = 4'h3;
	localparam logic [3:0]  SRC_WAKE = 4'ha;
	localparam logic [NUM_SRC-1:0][7:0] SRC_VECTOR = {
		8'h63, 8'h5b, 8'h53, 8'h4b, 8'h43,
		8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};

endpackage

/* File: design/ext_pin_sampler.sv */
`timescale 1ns/1ps
module ext_pin_sampler
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin_n,
	input  wire logic sample_strobe,
	output logic      sampled_low,
	output logic      fell,
	output logic      fresh
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
		logic fell;
		logic fresh;
	} sampler_t;

	sampler_t st;
	sampler_t next_st;

	// Synchronise, then take one sample per instruction boundary
	always_comb
	begin
		next_st       = st;
		next_st.sync1 = pin_n;
		next_st.sync2 = st.sync1;
		next_st.fell  = 1'b0;
		next_st.fresh = 1'b0;
		if (sample_strobe)
		begin
			next_st.last  = st.sync2;
			next_st.fresh = 1'b1;
			next_st.fell  = st.last & ~st.sync2; // High then low
		end
	end

	// Idle pin reads high
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '{sync1: 1'b1, sync2: 1'b1, last: 1'b1, fell: 1'b0, fresh: 1'b0};
		else
			st <= next_st;
	end

	assign sampled_low = ~st.last;
	assign fell        = st.fell;
	assign fresh       = st.fresh;

endmodule // ext_pin_sampler

/* File: design/two_level_vectored_irq_ctrl.sv */
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Timer1 rank 3 0x1b, serial 0x23, timer2 0x2b
// - Converter rank 8 0x43, peripheral-ready 0x4b
// - Ranks 6,7 spare; wakeup rank 12 0x63
// - Only a higher level pre-empts a routine
// - Vector only at an instruction boundary
// - Return or enable/priority write delays one instruction
// - Global enable bit 7 masks every source
// - Flags, enables, priorities at documented bit positions
// - Programmed level beats natural rank
// - Same level: lowest natural rank wins
// - Timer and serial set flags become pending
// - Pins sampled once per instruction boundary
// - Pins active low; type 0 follows level
// - Type 1 sets flag on high-then-low
// - Vector to source; resume after return
// - Wakeup flag cleared by software; write sets
module two_level_vectored_irq_ctrl
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic [31:0] haddr,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_request0_pin_n,
	input  wire logic        ext_request1_pin_n,
	input  wire logic        timer0_overflow_set,
	input  wire logic        timer1_overflow_set,
	input  wire logic        timer2_overflow_set,
	input  wire logic        timer2_external_set,
	input  wire logic        serial_tx_done_set,
	input  wire logic        serial_rx_done_set,
	input  wire logic        conv_done_set,
	input  wire logic        periph_ready_set,
	input  wire logic        wakeup_set,
	input  wire logic        instr_done,
	input  wire logic        instr_is_return_from_interrupt,
	input  wire logic        irq_ack,
	output logic             irq_req,
	output logic      [7:0]  irq_vector,
	output logic             irq_level
);
	import irq_ctrl_pkg::*;

	typedef struct packed {
		logic        dp_valid;
		logic        dp_write;
		logic [7:0]  dp_ofs;
		logic [31:0] rdata;
		logic [7:0]  basic_irq_enable_reg;
		logic [5:0]  basic_irq_priority_reg;
		logic [4:0]  extended_irq_enable_reg;
		logic [4:0]  extended_irq_priority_reg;
		logic [3:0]  ext_flags;
		logic        wakeup_flag;
		logic        ext0_type_select;
		logic        ext1_type_select;
		logic        ext0_pending_flag;
		logic        ext1_pending_flag;
		logic        timer0_overflow_flag;
		logic        timer1_overflow_flag;
		logic        serial_rx_done_flag;
		logic        serial_tx_done_flag;
		logic        timer2_overflow_flag;
		logic        timer2_external_flag;
		logic        prio_written;
		logic        req;
		logic [7:0]  vector;
		logic [3:0]  src;
		logic        level;
		logic        act_low;
		logic        act_high;
	} state_t;

	state_t             st;
	state_t             next_st;
	logic               ext0_low;
	logic               ext0_fell;
	logic               ext0_fresh;
	logic               ext1_low;
	logic               ext1_fell;
	logic               ext1_fresh;
	logic [NUM_SRC-1:0] src_flag;
	logic [NUM_SRC-1:0] src_en;
	logic [NUM_SRC-1:0] src_lvl;
	logic [NUM_SRC-1:0] pend;
	logic               hi_found;
	logic               lo_found;
	logic [3:0]         hi_idx;
	logic [3:0]         lo_idx;
	logic               cand_ok;
	logic [3:0]         cand_src;
	logic               cand_lvl;
	logic               prio_wr_now;
	logic               block_vec;

	////////////////////////////////////////////////////////////////////////////////
	// External pin samplers
	ext_pin_sampler u_ext0
	(
		.hclk          (hclk),
		.hresetn       (hresetn),
		.pin_n         (ext_request0_pin_n),
		.sample_strobe (instr_done),
		.sampled_low   (ext0_low),
		.fell          (ext0_fell),
		.fresh         (ext0_fresh)
	);
	ext_pin_sampler u_ext1
	(
		.hclk          (hclk),
		.hresetn       (hresetn),
		.pin_n         (ext_request1_pin_n),
		.sample_strobe (instr_done),
		.sampled_low   (ext1_low),
		.fell          (ext1_fell),
		.fresh         (ext1_fresh)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register read mux
	function automatic logic [31:0] read_word(input state_t s, input logic [7:0] ofs);
		logic [7:0] b;
		b = RST_BYTE;
		case (ofs)
			OFS_BASIC_EN:   b = s.basic_irq_enable_reg;
			OFS_BASIC_PRIO: b = {2'h0, s.basic_irq_priority_reg};
			OFS_EXT_EN:     b = {RSVD_ONES, s.extended_irq_enable_reg};
			OFS_EXT_PRIO:   b = {RSVD_ONES, s.extended_irq_priority_reg};
			OFS_EXT_FLAG:   b[EXT_FLAG_LSB +: 4] = s.ext_flags;
			OFS_EXT_CTRL:   b[WAKE_BIT] = s.wakeup_flag;
			OFS_TIMER_CTRL:
			begin
				b[IT0_BIT] = s.ext0_type_select;
				b[IE0_BIT] = s.ext0_pending_flag;
				b[IT1_BIT] = s.ext1_type_select;
				b[IE1_BIT] = s.ext1_pending_flag;
				b[TF0_BIT] = s.timer0_overflow_flag;
				b[TF1_BIT] = s.timer1_overflow_flag;
			end
			OFS_SERIAL:
			begin
				b[RX_BIT] = s.serial_rx_done_flag;
				b[TX_BIT] = s.serial_tx_done_flag;
			end
			OFS_T2_CTRL:
			begin
				b[TIMER2_EXTERNAL_FLAG_BIT] = s.timer2_external_flag;
				b[TF2_BIT]  = s.timer2_overflow_flag;
			end
			OFS_STATUS:
				return {20'h0, s.act_high, s.act_low, s.level, s.req, s.vector};
			default:        b = RST_BYTE;
		endcase
		return {24'h0, b};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Source vectors and arbitration
	// Pending flags per source, natural order
	always_comb
	begin
		src_flag = {st.wakeup_flag, st.ext_flags,
			st.timer2_overflow_flag | st.timer2_external_flag,
			st.serial_rx_done_flag | st.serial_tx_done_flag,
			st.timer1_overflow_flag, st.ext1_pending_flag,
			st.timer0_overflow_flag, st.ext0_pending_flag};
		src_en  = {st.extended_irq_enable_reg, st.basic_irq_enable_reg[5:0]};
		src_lvl = {st.extended_irq_priority_reg, st.basic_irq_priority_reg};
		pend    = src_flag & src_en & {NUM_SRC{st.basic_irq_enable_reg[GLOBAL_EN_BIT]}};
	end

	// Best source at each level; descending loop leaves lowest index
	always_comb
	begin
		hi_found = 1'b0;
		lo_found = 1'b0;
		hi_idx   = 4'h0;
		lo_idx   = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (pend[i] && src_lvl[i])
			begin
				hi_found = 1'b1;
				hi_idx   = 4'(i);
			end
			if (pend[i] && !src_lvl[i])
			begin
				lo_found = 1'b1;
				lo_idx   = 4'(i);
			end
		end
	end

	// Level first, then in-service check
	always_comb
	begin
		cand_lvl = hi_found;
		cand_src = hi_found ? hi_idx : lo_idx;
		cand_ok  = hi_found ? !st.act_high : (lo_found && !st.act_high && !st.act_low);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_st     = st;
		prio_wr_now = st.dp_valid && st.dp_write &&
			(st.dp_ofs == OFS_BASIC_EN || st.dp_ofs == OFS_BASIC_PRIO ||
			st.dp_ofs == OFS_EXT_EN || st.dp_ofs == OFS_EXT_PRIO);
		block_vec   = instr_is_return_from_interrupt || st.prio_written || prio_wr_now;
		// Bus data phase writes
		if (st.dp_valid && st.dp_write)
		begin
			case (st.dp_ofs)
				OFS_BASIC_EN:   next_st.basic_irq_enable_reg = hwdata[7:0];
				OFS_BASIC_PRIO: next_st.basic_irq_priority_reg = hwdata[5:0];
				OFS_EXT_EN:     next_st.extended_irq_enable_reg = hwdata[4:0];
				OFS_EXT_PRIO:   next_st.extended_irq_priority_reg = hwdata[4:0];
				OFS_EXT_FLAG:   next_st.ext_flags = hwdata[EXT_FLAG_LSB +: 4];
				OFS_EXT_CTRL:   next_st.wakeup_flag = hwdata[WAKE_BIT];
				OFS_TIMER_CTRL:
				begin
					next_st.ext0_type_select     = hwdata[IT0_BIT];
					next_st.ext0_pending_flag    = hwdata[IE0_BIT];
					next_st.ext1_type_select     = hwdata[IT1_BIT];
					next_st.ext1_pending_flag    = hwdata[IE1_BIT];
					next_st.timer0_overflow_flag = hwdata[TF0_BIT];
					next_st.timer1_overflow_flag = hwdata[TF1_BIT];
				end
				OFS_SERIAL:
				begin
					next_st.serial_rx_done_flag = hwdata[RX_BIT];
					next_st.serial_tx_done_flag = hwdata[TX_BIT];
				end
				OFS_T2_CTRL:
				begin
					next_st.timer2_external_flag = hwdata[TIMER2_EXTERNAL_FLAG_BIT];
					next_st.timer2_overflow_flag = hwdata[TF2_BIT];
				end
				default: next_st.rdata = st.rdata;
			endcase
		end
		// Vector taken by the core
		if (irq_ack && st.req)
		begin
			next_st.req      = 1'b0;
			next_st.act_high = st.act_high || st.level;
			next_st.act_low  = st.act_low || !st.level;
			if (st.src == SRC_EXT0 && st.ext0_type_select)
				next_st.ext0_pending_flag = 1'b0;
			if (st.src == SRC_EXT1 && st.ext1_type_select)
				next_st.ext1_pending_flag = 1'b0;
		end
		// Hardware sets win over any clear
		next_st.timer0_overflow_flag |= timer0_overflow_set;
		next_st.timer1_overflow_flag |= timer1_overflow_set;
		next_st.timer2_overflow_flag |= timer2_overflow_set;
		next_st.timer2_external_flag |= timer2_external_set;
		next_st.serial_tx_done_flag  |= serial_tx_done_set;
		next_st.serial_rx_done_flag  |= serial_rx_done_set;
		next_st.ext_flags[0] |= conv_done_set;
		next_st.ext_flags[1] |= periph_ready_set;
		next_st.wakeup_flag  |= wakeup_set;
		// External pins: edge latches, level follows
		if (st.ext0_type_select)
			next_st.ext0_pending_flag |= ext0_fell;
		else if (ext0_fresh)
			next_st.ext0_pending_flag = ext0_low;
		if (st.ext1_type_select)
			next_st.ext1_pending_flag |= ext1_fell;
		else if (ext1_fresh)
			next_st.ext1_pending_flag = ext1_low;
		// Instruction boundary: return, then vectoring
		next_st.prio_written = !instr_done && (st.prio_written || prio_wr_now);
		if (instr_done)
		begin
			next_st.act_high = next_st.act_high && !(instr_is_return_from_interrupt && st.act_high);
			next_st.act_low  = next_st.act_low && !(instr_is_return_from_interrupt && !st.act_high);
			if (!st.req && !block_vec && cand_ok)
			begin
				next_st.req    = 1'b1;
				next_st.src    = cand_src;
				next_st.level  = cand_lvl;
				next_st.vector = SRC_VECTOR[cand_src];
			end
		end
		// Bus address phase, read data taken now
		next_st.dp_valid = hsel && htrans[1] && hready && hsize == HSIZE_WORD &&
			haddr[31:8] == 24'h0;
		next_st.dp_write = hwrite;
		next_st.dp_ofs   = haddr[7:0];
		if (next_st.dp_valid && !hwrite)
			next_st.rdata = read_word(st, haddr[7:0]);
		else if (hsel && htrans[1] && hready)
			next_st.rdata = 32'h0;
	end
	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end
	// Outputs
	assign hrdata     = st.rdata;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign irq_req    = st.req;
	assign irq_vector = st.vector;
	assign irq_level  = st.level;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_raise;
		!irq_req ##1 irq_req;
	endsequence
	sequence s_return_from_interrupt_end;
		instr_done && instr_is_return_from_interrupt;
	endsequence
	a_vector_table: assert property (irq_req |-> irq_vector == SRC_VECTOR[st.src])
		else $error("vector does not match source");
	a_timer1_vec: assert property (irq_req && st.src == SRC_T1 |-> irq_vector == 8'h1b)
		else $error("timer one vector wrong");
	a_wake_vec: assert property (irq_req && st.src == SRC_WAKE |-> irq_vector == 8'h63)
		else $error("wakeup vector wrong");
	a_boundary_only: assert property (s_raise |-> $past(instr_done))
		else $error("request raised off an instruction boundary");
	a_return_from_interrupt_extra: assert property (s_return_from_interrupt_end |=> !$rose(irq_req))
		else $error("vectored right after a return");
	a_global_mask: assert property (s_raise |-> $past(st.basic_irq_enable_reg[GLOBAL_EN_BIT]))
		else $error("vectored with global enable clear");
	a_no_preempt_high: assert property (s_raise |-> !$past(st.act_high))
		else $error("high routine pre-empted");
	a_low_needs_high: assert property (s_raise ##0 $past(st.act_low) |-> irq_level)
		else $error("low routine pre-empted by low request");
	a_level_first: assert property (s_raise ##0 !irq_level |-> !$past(hi_found))
		else $error("low level served over pending high");
	a_edge_sets: assert property (ext0_fell && st.ext0_type_select |=> st.ext0_pending_flag)
		else $error("falling edge not latched");
	a_level_follow: assert property (ext0_fresh && !st.ext0_type_select
		|=> st.ext0_pending_flag == $past(ext0_low))
		else $error("level flag does not follow pin");
	a_sample_once: assert property (ext0_fresh |-> $past(instr_done))
		else $error("pin sampled off boundary");
	a_edge_clear: assert property (irq_ack && irq_req && st.src == SRC_EXT0 &&
		st.ext0_type_select && !ext0_fell |=> !st.ext0_pending_flag)
		else $error("edge flag not cleared on vectoring");
	a_ack_drops: assert property (irq_ack && irq_req |=> !irq_req ##1 1'b1)
		else $error("request held after acknowledge");
endmodule // two_level_vectored_irq_ctrl

/* File: sim/irq_core_model.sv */
`timescale 1ns/1ps
module irq_core_model
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       irq_req,
	input  wire logic       return_from_interrupt_req,
	input  wire logic [3:0] ack_wait,
	output logic            instr_done,
	output logic            instr_is_return_from_interrupt,
	output logic            irq_ack
);
	logic [1:0] phase;
	logic [3:0] waited;

	////////////////////////////////////////////////////////////////
	// Four-clock instruction cycle, boundary strobe at C4
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase      <= 2'h0;
			instr_done <= 1'b0;
		end
		else
		begin
			phase      <= phase + 2'h1;
			instr_done <= (phase == 2'h2);
		end
	end

	// Return only at an instruction boundary
	assign instr_is_return_from_interrupt = instr_done & return_from_interrupt_req;

	// Vector taken after a chosen wait, one pulse per request
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			waited  <= 4'h0;
			irq_ack <= 1'b0;
		end
		else
		begin
			irq_ack <= irq_req && !irq_ack && (waited >= ack_wait);
			waited  <= (irq_req && !irq_ack) ? waited + 4'h1 : 4'h0;
		end
	end
endmodule // irq_core_model

/* File: sim/two_level_vectored_irq_ctrl_bench.sv */
`timescale 1ns/1ps
module two_level_vectored_irq_ctrl_bench;
	import irq_ctrl_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        pin0_n;
	logic        pin1_n;
	logic [8:0]  sets;
	logic        instr_done;
	logic        instr_is_return_from_interrupt;
	logic        irq_ack;
	logic        irq_req;
	logic [7:0]  irq_vector;
	logic        irq_level;
	logic        return_from_interrupt_req;
	logic [3:0]  ack_wait;
	logic        prev_done;
	int          num_errors;
	int          check_count;
	int          cycles;

	////////////////////////////////////////////////////////////////
	// Block, core model and clock
	two_level_vectored_irq_ctrl u_dut
	(
		.hclk, .hresetn, .hsel, .htrans, .haddr, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.ext_request0_pin_n(pin0_n), .ext_request1_pin_n(pin1_n),
		.timer0_overflow_set(sets[0]), .timer1_overflow_set(sets[1]),
		.timer2_overflow_set(sets[2]), .timer2_external_set(sets[3]),
		.serial_tx_done_set(sets[4]), .serial_rx_done_set(sets[5]),
		.conv_done_set(sets[6]), .periph_ready_set(sets[7]), .wakeup_set(sets[8]),
		.instr_done, .instr_is_return_from_interrupt, .irq_ack, .irq_req, .irq_vector, .irq_level
	);

	irq_core_model u_core
	(
		.hclk, .hresetn, .irq_req, .return_from_interrupt_req, .ack_wait, .instr_done, .instr_is_return_from_interrupt, .irq_ack
	);

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// Boundary seen at the last edge, and hang guard
	always @(posedge hclk)
	begin
		prev_done <= instr_done;
		cycles    <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One AHB-Lite word transfer, read data taken at the data-phase edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, {24'h0, d}, q);
	endtask

	task automatic pulse(input logic [8:0] m);
		@(posedge hclk);
		sets <= m;
		@(posedge hclk);
		sets <= 9'h0;
	endtask

	// Flags written back to zero, then a return at the next boundary
	task automatic leave_isr();
		for (int k = 0; k < 5; k++)
			wr(8'(OFS_EXT_FLAG + 8'(4 * k)), 8'h00);
		@(posedge hclk);
		return_from_interrupt_req <= 1'b1;
		@(posedge hclk iff instr_done);
		return_from_interrupt_req <= 1'b0;
	endtask

	// Watch for a request over 40 cycles; judge vector and level
	task automatic expect_req(input logic r, input logic [7:0] v, input logic l);
		logic seen;
		seen = 1'b0;
		repeat (40)
		begin
			@(negedge hclk);
			if (!seen && irq_req === 1'b1)
			begin
				seen = 1'b1;
				check({31'h0, prev_done}, 32'h1);
				check({24'h0, irq_vector}, {24'h0, v});
				check({31'h0, irq_level}, {31'h0, l});
			end
		end
		check({31'h0, seen}, {31'h0, r});
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		logic [7:0]  a [4] = '{OFS_BASIC_EN, OFS_EXT_EN, OFS_EXT_PRIO, 8'h80};
		logic [31:0] e [4] = '{32'h0, 32'he0, 32'he0, 32'h0};
		logic [31:0] d;
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b0, a[i], 32'h0, d);
			check(d, e[i]);
		end
		check({31'h0, hresp}, 32'h0);
		check({31'h0, hreadyout}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_vectors();
		logic [7:0] vec [9] = '{8'h0b, 8'h1b, 8'h2b, 8'h2b, 8'h23, 8'h23, 8'h43, 8'h4b, 8'h63};
		logic [7:0] swa [3] = '{OFS_EXT_FLAG, OFS_EXT_FLAG, OFS_EXT_CTRL};
		logic [7:0] swd [3] = '{8'h40, 8'h80, 8'h08};
		logic [7:0] swv [3] = '{8'h53, 8'h5b, 8'h63};
		wr(OFS_BASIC_EN, 8'hbe);
		wr(OFS_EXT_EN, 8'h1f);
		for (int i = 0; i < 9; i++)
		begin
			pulse(9'(1 << i));
			expect_req(1'b1, vec[i], 1'b0);
			leave_isr();
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(swa[i], swd[i]);
			expect_req(1'b1, swv[i], 1'b0);
			leave_isr();
		end
		$display("test vectors done");
	endtask

	task automatic t_mask();
		wr(OFS_BASIC_EN, 8'h3e);
		pulse(9'h001);
		expect_req(1'b0, 8'h00, 1'b0);
		@(posedge hclk iff instr_done);
		wr(OFS_BASIC_EN, 8'hbe);
		@(posedge hclk iff instr_done);
		@(negedge hclk);
		check({31'h0, irq_req}, 32'h0);
		@(posedge hclk iff instr_done);
		@(negedge hclk);
		check({31'h0, irq_req}, 32'h1);
		leave_isr();
		$display("test mask done");
	endtask

	task automatic t_priority();
		logic [31:0] d;
		ack_wait <= 4'h6;
		wr(OFS_BASIC_PRIO, 8'h08);
		pulse(9'h003);
		expect_req(1'b1, 8'h1b, 1'b1);
		xfer(1'b0, OFS_STATUS, 32'h0, d);
		check(d, 32'ha1b);
		wr(OFS_TIMER_CTRL, 8'h20);
		leave_isr();
		wr(OFS_BASIC_PRIO, 8'h00);
		pulse(9'h003);
		expect_req(1'b1, 8'h0b, 1'b0);
		leave_isr();
		ack_wait <= 4'h0;
		$display("test priority done");
	endtask

	task automatic t_preempt();
		wr(OFS_BASIC_PRIO, 8'h08);
		pulse(9'h001);
		expect_req(1'b1, 8'h0b, 1'b0);
		pulse(9'h010);
		expect_req(1'b0, 8'h00, 1'b0);
		pulse(9'h002);
		expect_req(1'b1, 8'h1b, 1'b1);
		wr(OFS_TIMER_CTRL, 8'h20);
		@(posedge hclk);
		return_from_interrupt_req <= 1'b1;
		@(posedge hclk iff instr_done);
		return_from_interrupt_req <= 1'b0;
		expect_req(1'b0, 8'h00, 1'b0);
		wr(OFS_TIMER_CTRL, 8'h00);
		leave_isr();
		pulse(9'h010);
		expect_req(1'b1, 8'h23, 1'b0);
		leave_isr();
		wr(OFS_BASIC_PRIO, 8'h00);
		$display("test preempt done");
	endtask

	task automatic t_pins();
		logic [31:0] d;
		wr(OFS_BASIC_EN, 8'h81);
		wr(OFS_TIMER_CTRL, 8'h01);
		repeat (4) @(posedge hclk);
		pin0_n <= 1'b0;
		repeat (4) @(posedge hclk);
		pin0_n <= 1'b1;
		expect_req(1'b1, 8'h03, 1'b0);
		xfer(1'b0, OFS_TIMER_CTRL, 32'h0, d);
		check(d, 32'h01);
		leave_isr();
		pin0_n <= 1'b0;
		expect_req(1'b1, 8'h03, 1'b0);
		xfer(1'b0, OFS_TIMER_CTRL, 32'h0, d);
		check(d, 32'h02);
		pin0_n <= 1'b1;
		repeat (12) @(posedge hclk);
		xfer(1'b0, OFS_TIMER_CTRL, 32'h0, d);
		check(d, 32'h00);
		leave_isr();
		expect_req(1'b0, 8'h00, 1'b0);
		wr(OFS_BASIC_EN, 8'h84);
		wr(OFS_TIMER_CTRL, 8'h04);
		repeat (4) @(posedge hclk);
		pin1_n <= 1'b0;
		repeat (4) @(posedge hclk);
		pin1_n <= 1'b1;
		expect_req(1'b1, 8'h13, 1'b0);
		xfer(1'b0, OFS_TIMER_CTRL, 32'h0, d);
		check(d, 32'h04);
		leave_isr();
		$display("test pins done");
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		hresetn     = 1'b0;
		hsel        = 1'b0;
		htrans      = 2'h0;
		haddr       = 32'h0;
		hwrite      = 1'b0;
		hsize       = HSIZE_WORD;
		hwdata      = 32'h0;
		pin0_n      = 1'b1;
		pin1_n      = 1'b1;
		sets        = 9'h0;
		return_from_interrupt_req    = 1'b0;
		ack_wait    = 4'h0;
		num_errors  = 0;
		check_count = 0;
		cycles      = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_vectors();
		t_mask();
		t_priority();
		t_preempt();
		t_pins();
		wrap_up();
	end
endmodule // two_level_vectored_irq_ctrl_bench
